// *** src/ssi_position_readout.sv ***
// Functional notes
// - The first falling link clock edge of a read captures the position word, held for the read.
// - Each rising link clock edge drives the next word bit, most significant first.
// - After the transfer and the transfer timeout the data line returns high.
// - A clock idle longer than the transfer timeout during a read aborts that read.
// - Without battery the turn count is lost on power loss and cleared when power returns.
// - With battery the block keeps tracking turns on battery and reports the kept count.
// - On battery, rotation is tracked up to a configurable standby speed, 6000 rpm by default.
// - The word holds 16-bit turns, angle, error, warning and 6-bit status, turns only multi-turn.
// - After a first low phase of 500 ns, further link clock edges are accepted up to 10 MHz.
`timescale 1ns/1ps
`default_nettype none

module ssi_position_readout #(
	parameter int ANGLE_W = ssi_pkg::ANGLE_W_DEF,
	parameter bit MULTI_TURN = 1'b1,
	parameter bit BATTERY = 1'b1,
	parameter int TIMEOUT_CYC = ssi_pkg::TRANSFER_TIMEOUT_CYC,
	parameter int PAUSE_CYC = ssi_pkg::PAUSE_DURATION_CYC,
	parameter int STANDBY_SAMPLE_CYC = ssi_pkg::STANDBY_SAMPLE_CYC
) (
	// system clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link pins
	input wire logic ssi_clk,
	output logic ssi_data,
	// sensor front end
	input wire logic [ANGLE_W-1:0] angle,
	input wire logic angle_valid,
	input wire logic err_n,
	input wire logic warn_n,
	input wire logic [ssi_pkg::STATUS_W-1:0] status,
	// supply monitor pin
	input wire logic main_pwr_ok,
	// status outputs
	output logic battery_mode,
	output logic [ssi_pkg::TURN_W-1:0] turn_count,
	output logic link_ready
);

	localparam int FULL_W = ssi_pkg::TURN_W + ANGLE_W + ssi_pkg::FLAG_W + ssi_pkg::STATUS_W;
	localparam int WORD_W = MULTI_TURN ? FULL_W : FULL_W - ssi_pkg::TURN_W;
	localparam int CNT_W = $clog2((TIMEOUT_CYC > PAUSE_CYC ? TIMEOUT_CYC : PAUSE_CYC) + 1);
	localparam int SB_W = $clog2(STANDBY_SAMPLE_CYC + 1);
	localparam logic [CNT_W-1:0] TIMEOUT_LAST = CNT_W'(TIMEOUT_CYC - 1);
	localparam logic [CNT_W-1:0] PAUSE_LAST = CNT_W'(PAUSE_CYC - 1);
	localparam logic [SB_W-1:0] SB_LAST = SB_W'(STANDBY_SAMPLE_CYC - 1);

	typedef struct packed {
		logic [ssi_pkg::SYNC_STAGES-1:0] clk_sync;
		logic [ssi_pkg::SYNC_STAGES-1:0] pwr_sync;
		logic clk_lvl;
		logic pwr_lvl;
		ssi_pkg::link_state_t st;
		logic [CNT_W-1:0] idle_cnt;
		logic link_rst;
		logic [WORD_W-1:0] hold;
		logic [ssi_pkg::TURN_W-1:0] turns;
		logic [1:0] last_quad;
		logic quad_ok;
		logic batt;
		logic [SB_W-1:0] sb_cnt;
	} sys_t;

	sys_t s_q;
	sys_t s_d;

	logic link_rst_w;

	// quadrant of the angle, the top two bits
	function automatic logic [1:0] quad_of(input logic [ANGLE_W-1:0] a);
		quad_of = a[ANGLE_W-1 -: 2];
	endfunction

	// step the turn count on a quadrant wrap in either direction
	function automatic logic [ssi_pkg::TURN_W-1:0] turn_step(
		input logic [ssi_pkg::TURN_W-1:0] t,
		input logic [1:0] from_q,
		input logic [1:0] to_q
	);
		turn_step = t;
		if (from_q == 2'b11 && to_q == 2'b00)
			turn_step = t + 1'b1;
		else if (from_q == 2'b00 && to_q == 2'b11)
			turn_step = t - 1'b1;
	endfunction

	// a pin change counts once synchroniser stages two and three agree
	function automatic logic settled(input logic [ssi_pkg::SYNC_STAGES-1:0] s);
		settled = (s[1] == s[2]);
	endfunction

	always_comb
	begin
		logic [FULL_W-1:0] full;
		logic clk_agree;
		logic clk_edge;
		logic pwr_agree;
		logic pwr_rise;
		logic pwr_fall;
		logic sample;
		logic sb_tick;

		full = '0;
		clk_agree = 1'b0;
		clk_edge = 1'b0;
		pwr_agree = 1'b0;
		pwr_rise = 1'b0;
		pwr_fall = 1'b0;
		sample = 1'b0;
		sb_tick = 1'b0;
		s_d = s_q;

		// pin synchronisers: a change counts once stages two and three agree
		s_d.clk_sync = {s_q.clk_sync[1:0], ssi_clk};
		s_d.pwr_sync = {s_q.pwr_sync[1:0], main_pwr_ok};
		clk_agree = settled(s_q.clk_sync);
		pwr_agree = settled(s_q.pwr_sync);
		clk_edge = clk_agree && (s_q.clk_sync[2] != s_q.clk_lvl);
		pwr_rise = pwr_agree && s_q.pwr_sync[2] && !s_q.pwr_lvl;
		pwr_fall = pwr_agree && !s_q.pwr_sync[2] && s_q.pwr_lvl;
		if (clk_agree)
			s_d.clk_lvl = s_q.clk_sync[2];
		if (pwr_agree)
			s_d.pwr_lvl = s_q.pwr_sync[2];

		// word as shifted, turns on top and dropped on single-turn builds
		full = {s_q.turns, angle, err_n, warn_n, status};

		// frame control
		unique case (s_q.st)
			ssi_pkg::LS_HOLD:
			begin
				s_d.link_rst = 1'b1;
				s_d.hold = full[WORD_W-1:0];
				if (clk_edge || !s_q.clk_lvl || !s_q.pwr_lvl)
					s_d.idle_cnt = '0;
				else if (s_q.idle_cnt == PAUSE_LAST)
				begin
					s_d.st = ssi_pkg::LS_READY;
					s_d.link_rst = 1'b0;
					s_d.idle_cnt = '0;
				end
				else
					s_d.idle_cnt = s_q.idle_cnt + 1'b1;
			end
			ssi_pkg::LS_READY:
			begin
				// snapshot source frozen so the link fall samples a stable word
				s_d.idle_cnt = '0;
				if (!s_q.pwr_lvl)
				begin
					s_d.st = ssi_pkg::LS_HOLD;
					s_d.link_rst = 1'b1;
				end
				else if (clk_edge)
					s_d.st = ssi_pkg::LS_ACTIVE;
			end
			ssi_pkg::LS_ACTIVE:
			begin
				if (clk_edge)
					s_d.idle_cnt = '0;
				else if (s_q.idle_cnt == TIMEOUT_LAST || !s_q.pwr_lvl)
				begin
					// end of frame or abort: data line back high
					s_d.st = ssi_pkg::LS_HOLD;
					s_d.link_rst = 1'b1;
					s_d.idle_cnt = '0;
				end
				else
					s_d.idle_cnt = s_q.idle_cnt + 1'b1;
			end
			default:
			begin
				s_d.st = ssi_pkg::LS_HOLD;
				s_d.link_rst = 1'b1;
				s_d.idle_cnt = '0;
			end
		endcase

		// standby sampling tick while on battery
		if (s_q.batt)
		begin
			if (s_q.sb_cnt == SB_LAST)
			begin
				s_d.sb_cnt = '0;
				sb_tick = 1'b1;
			end
			else
				s_d.sb_cnt = s_q.sb_cnt + 1'b1;
		end
		else
			s_d.sb_cnt = '0;

		// turn tracking; supply return samples too, so a wrap made since the
		// last standby sample still counts; the first sample only sets the quadrant
		sample = pwr_rise ||
			(s_q.pwr_lvl ? angle_valid : (BATTERY && s_q.batt && sb_tick));
		if (sample)
		begin
			if (s_q.quad_ok)
				s_d.turns = turn_step(s_q.turns, s_q.last_quad, quad_of(angle));
			s_d.last_quad = quad_of(angle);
			s_d.quad_ok = 1'b1;
		end

		// supply transitions
		if (pwr_fall && BATTERY)
			s_d.batt = 1'b1;
		if (pwr_rise)
		begin
			s_d.batt = 1'b0;
			if (!BATTERY)
				s_d.turns = ssi_pkg::TURN_RST;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_q <= '0;
			// pins taken at their idle levels, so no false edge follows reset
			s_q.clk_sync <= '1;
			s_q.pwr_sync <= '1;
			s_q.clk_lvl <= 1'b1;
			s_q.pwr_lvl <= 1'b1;
			s_q.st <= ssi_pkg::LS_HOLD;
			s_q.link_rst <= 1'b1;
			s_q.turns <= ssi_pkg::TURN_RST;
		end
		else
			s_q <= s_d;
	end

	// link side is held in reset in the hold state, from the end of a frame through the pause
	assign link_rst_w = s_q.link_rst | sys_rst;

	ssi_link_shifter #(
		.WORD_W(WORD_W)
	) u_shifter (
		.ssi_clk(ssi_clk),
		.link_rst(link_rst_w),
		.snap_word(s_q.hold),
		.ssi_data(ssi_data)
	);

	assign battery_mode = s_q.batt;
	assign turn_count = s_q.turns;
	assign link_ready = (s_q.st == ssi_pkg::LS_READY);

endmodule

`default_nettype wire

// *** src/ssi_pkg.sv ***
package ssi_pkg;

	// system clock
	localparam int CLK_PERIOD_NS = 20;

	// link framing times and their cycle counts (least times, rounded up)
	localparam int TRANSFER_TIMEOUT_NS = 10000;
	localparam int PAUSE_DURATION_NS = 20000;
	localparam int TRANSFER_TIMEOUT_CYC = (TRANSFER_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAUSE_DURATION_CYC = (PAUSE_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// first low phase that unlocks fast clocking on the link
	localparam int FAST_FIRST_LOW_NS = 500;

	// word layout, msb first: turns, angle, error, warning, status
	localparam int TURN_W = 16;
	localparam int ANGLE_W_DEF = 17;
	localparam int FLAG_W = 2;
	localparam int STATUS_W = 6;
	localparam int STATUS_LSB = 0;
	localparam int WARN_POS = STATUS_W;
	localparam int ERR_POS = STATUS_W + 1;
	localparam int ANGLE_LSB = STATUS_W + FLAG_W;

	// reset values
	localparam logic [TURN_W-1:0] TURN_RST = 16'h0000;
	localparam logic DATA_IDLE = 1'h1;

	// battery standby tracking
	localparam int STANDBY_RPM_DEF = 6000;
	localparam int SAMPLES_PER_TURN = 4;
	localparam longint NS_PER_MIN = 64'h0000_000D_F847_5800;
	localparam longint STANDBY_SAMPLE_CYC_L =
		NS_PER_MIN / (longint'(STANDBY_RPM_DEF) * SAMPLES_PER_TURN * CLK_PERIOD_NS);
	localparam int STANDBY_SAMPLE_CYC = int'(STANDBY_SAMPLE_CYC_L);

	// synchroniser depth for pins
	localparam int SYNC_STAGES = 3;

	// frame control states
	typedef enum logic [1:0] {
		LS_HOLD = 2'b00,
		LS_READY = 2'b01,
		LS_ACTIVE = 2'b10
	} link_state_t;

endpackage

// *** src/ssi_link_shifter.sv ***
`timescale 1ns/1ps
`default_nettype none

// link-clock side: capture on first fall, present one bit per rise
module ssi_link_shifter #(
	parameter int WORD_W = 41
) (
	// link clock and frame reset
	input wire logic ssi_clk,
	input wire logic link_rst,
	// word held stable by the system side while a frame may start
	input wire logic [WORD_W-1:0] snap_word,
	// serial data line
	output logic ssi_data
);

	localparam int CW = $clog2(WORD_W + 1);

	typedef struct packed {
		logic captured;
		logic [WORD_W-1:0] word;
		logic [CW-1:0] left;
	} shift_t;

	shift_t s_q;
	shift_t s_d;
	logic data_q;

	// falling edges: snapshot on the first, then count off sampled bits
	always_comb
	begin
		s_d = s_q;
		if (!s_q.captured)
		begin
			s_d.captured = 1'b1;
			s_d.word = snap_word;
			s_d.left = CW'(WORD_W);
		end
		else if (s_q.left != '0)
		begin
			s_d.left = s_q.left - 1'b1;
		end
	end

	// edge-driven only, so the first-low and fast-rate timing is up to the clock
	always_ff @(negedge ssi_clk or posedge link_rst)
	begin
		if (link_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// rising edges: msb first, low once the word is exhausted
	always_ff @(posedge ssi_clk or posedge link_rst)
	begin
		if (link_rst)
			data_q <= ssi_pkg::DATA_IDLE;
		else if (!s_q.captured)
			data_q <= ssi_pkg::DATA_IDLE;
		else if (s_q.left != '0)
			data_q <= s_q.word[CW'(s_q.left - 1'b1)];
		else
			data_q <= 1'b0;
	end

	assign ssi_data = data_q;

endmodule

`default_nettype wire

// *** verif/ssi_readout_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssi_readout_props #(
	parameter int ANGLE_W = 17,
	parameter int TIMEOUT_CYC = 40,
	parameter int PAUSE_CYC = 60
) (
	// system side
	input wire logic clk,
	input wire logic sys_rst,
	// link pins
	input wire logic ssi_clk,
	input wire logic ssi_data,
	// sensor and supply
	input wire logic [ANGLE_W-1:0] angle,
	input wire logic angle_valid,
	input wire logic err_n,
	input wire logic warn_n,
	input wire logic [ssi_pkg::STATUS_W-1:0] status,
	input wire logic main_pwr_ok,
	// status
	input wire logic battery_mode,
	input wire logic [ssi_pkg::TURN_W-1:0] turn_count,
	input wire logic link_ready
);
	// cycles the link clock has stayed high
	logic [15:0] high_q;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			high_q <= 16'h0000;
		else if (!ssi_clk)
			high_q <= 16'h0000;
		else if (high_q != 16'hffff)
			high_q <= high_q + 16'h0001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_idle_data_high: assert property (link_ready |-> ssi_data)
		else $error("data line low while link idle");
	a_timeout_release: assert property (high_q == 16'(TIMEOUT_CYC + 12) |-> ssi_data)
		else $error("data line not released after timeout");
	a_pause_kept: assert property ($rose(link_ready) |-> high_q >= 16'(PAUSE_CYC))
		else $error("link ready before pause elapsed");
	a_data_on_rise: assert property ($changed(ssi_data) |-> ssi_clk)
		else $error("data changed while link clock low");
	a_ready_after_reset: assert property ($fell(sys_rst) |-> !link_ready [*8])
		else $error("link ready too early after reset");
	a_battery_no_read: assert property (battery_mode [*2] |-> !link_ready)
		else $error("link ready while on battery");
	a_turn_step: assert property ($changed(turn_count) |->
		turn_count == $past(turn_count) + 16'h0001 ||
		turn_count == $past(turn_count) - 16'h0001)
		else $error("turn count jumped by more than one");
	a_turn_cause: assert property ($changed(turn_count) && !battery_mode && !$past(battery_mode)
		|-> $past(angle_valid))
		else $error("turn count changed without angle update");
	cover property ($rose(link_ready));
	cover property ($rose(battery_mode));
	cover property (high_q == 16'(TIMEOUT_CYC + 12) && !link_ready);
endmodule
`default_nettype wire

// *** verif/ssi_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssi_master_model (
	// link pins
	output logic ssi_clk,
	input wire logic ssi_data
);
	initial ssi_clk = 1'b1;
	// clock stands high outside frames
	task automatic read(input int n, output logic [63:0] w);
		w = '0;
		// link edges kept off the system clock's edges
		#7;
		ssi_clk = 1'b0;
		#500;
		for (int i = 0; i < n; i++)
		begin
			ssi_clk = 1'b1;
			#80;
			w = {w[62:0], ssi_data};
			ssi_clk = 1'b0;
			#80;
		end
		ssi_clk = 1'b1;
	endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int TO = 40;
	localparam int PS = 60;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	wire logic ssi_clk;
	wire logic ssi_data;
	logic [16:0] angle = 17'h0_0000;
	logic angle_valid = 1'b0;
	logic err_n = 1'b1;
	logic warn_n = 1'b0;
	logic [5:0] status = 6'h25;
	logic main_pwr_ok = 1'b1;
	wire logic battery_mode;
	wire logic [15:0] turn_count;
	wire logic link_ready;
	wire logic plain_data;
	wire logic plain_batt;
	wire logic [15:0] plain_turns;
	wire logic plain_ready;
	logic [15:0] turns_exp = 16'h0000;
	int bad_count = 0;
	int checked = 0;
	always #10 clk = ~clk;
	ssi_position_readout #(.TIMEOUT_CYC(TO), .PAUSE_CYC(PS), .STANDBY_SAMPLE_CYC(20)) DUT (
		.clk(clk), .sys_rst(sys_rst), .ssi_clk(ssi_clk), .ssi_data(ssi_data),
		.angle(angle), .angle_valid(angle_valid), .err_n(err_n), .warn_n(warn_n),
		.status(status), .main_pwr_ok(main_pwr_ok), .battery_mode(battery_mode),
		.turn_count(turn_count), .link_ready(link_ready));
	// non-battery multi-turn build on the same pins
	ssi_position_readout #(.BATTERY(1'b0), .TIMEOUT_CYC(TO), .PAUSE_CYC(PS),
		.STANDBY_SAMPLE_CYC(20)) plain_dut (
		.clk(clk), .sys_rst(sys_rst), .ssi_clk(ssi_clk), .ssi_data(plain_data),
		.angle(angle), .angle_valid(angle_valid), .err_n(err_n), .warn_n(warn_n),
		.status(status), .main_pwr_ok(main_pwr_ok), .battery_mode(plain_batt),
		.turn_count(plain_turns), .link_ready(plain_ready));
	ssi_master_model m (.ssi_clk(ssi_clk), .ssi_data(ssi_data));
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// 0: link ready, 1: on battery, 2: off battery
	task automatic wait_for(input int sel);
		int n;
		n = 0;
		@(negedge clk);
		while (!((sel == 0 && link_ready === 1'b1) || (sel == 1 && battery_mode === 1'b1)
			|| (sel == 2 && battery_mode === 1'b0)))
		begin
			n++;
			if (n > 3000)
			begin
				bad_count++;
				end_of_test();
			end
			@(negedge clk);
		end
	endtask
	task automatic pulse(input logic [1:0] q);
		@(posedge clk);
		angle <= {q, 15'h0000};
		angle_valid <= 1'b1;
		@(posedge clk);
		angle_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic sc_turns();
		logic [1:0] q[6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h0};
		logic [15:0] t[6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001};
		for (int i = 0; i < 6; i++)
		begin
			pulse(q[i]);
			check("turns", turn_count, t[i]);
		end
		turns_exp = 16'h0001;
	endtask
	task automatic sc_frame();
		logic [40:0] exp;
		logic [63:0] got;
		wait_for(0);
		exp = {turns_exp, angle, err_n, warn_n, status};
		fork
			m.read(41, got);
			begin
				repeat (60) @(posedge clk);
				angle <= ~angle;
				status <= ~status;
				err_n <= ~err_n;
			end
		join
		check("frame word", got, 64'(exp));
		repeat (TO + 12) @(negedge clk);
		check("data released", ssi_data, 1'b1);
		check("ready in pause", link_ready, 1'b0);
	endtask
	task automatic sc_abort();
		logic [40:0] exp;
		logic [63:0] got;
		wait_for(0);
		exp = {turns_exp, angle, err_n, warn_n, status};
		m.read(10, got);
		check("aborted head", got, 64'(exp[40:31]));
		wait_for(0);
		check("line after abort", ssi_data, 1'b1);
		check("plain line after abort", plain_data, 1'b1);
		m.read(41, got);
		check("word after abort", got, 64'(exp));
	endtask
	task automatic sc_battery();
		logic [63:0] got;
		pulse(2'h3);
		check("turns down", turn_count, 16'h0000);
		main_pwr_ok <= 1'b0;
		wait_for(1);
		repeat (2) @(negedge clk);
		check("no read on battery", link_ready, 1'b0);
		check("plain not on battery", plain_batt, 1'b0);
		@(posedge clk);
		angle <= 17'h0_0000;
		repeat (60) @(negedge clk);
		check("turns on battery", turn_count, 16'h0001);
		check("plain ignores angle off power", plain_turns, 16'h0000);
		@(posedge clk);
		main_pwr_ok <= 1'b1;
		wait_for(2);
		check("turns kept", turn_count, 16'h0001);
		check("plain turns cleared", plain_turns, 16'h0000);
		wait_for(0);
		m.read(41, got);
		check("word after battery", got, 64'({16'h0001, angle, err_n, warn_n, status}));
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		check("turns at power on", turn_count, 16'h0000);
		check("plain turns at power on", plain_turns, 16'h0000);
		check("battery at power on", battery_mode, 1'b0);
		sc_turns();
		sc_frame();
		sc_abort();
		sc_battery();
		end_of_test();
	end
endmodule
bind ssi_position_readout ssi_readout_props #(.ANGLE_W(ANGLE_W), .TIMEOUT_CYC(TIMEOUT_CYC),
	.PAUSE_CYC(PAUSE_CYC)) chk (.clk(clk), .sys_rst(sys_rst), .ssi_clk(ssi_clk),
	.ssi_data(ssi_data), .angle(angle), .angle_valid(angle_valid), .err_n(err_n),
	.warn_n(warn_n), .status(status), .main_pwr_ok(main_pwr_ok),
	.battery_mode(battery_mode), .turn_count(turn_count), .link_ready(link_ready));
`default_nettype wire
